/* hw/pog_pkg.sv */
// package for the port one gpio block: register map, field layout, pin carriers
// Summary of operation
// [RULE1] eight-bit data latch, one bit per pin
// [RULE2] read of output pin returns latch value
// [RULE3] read of input pin returns pin level
// [RULE4] data latch resets to all zeros
// [RULE5] direction one makes output, zero input
// [RULE6] direction register resets to all inputs
// [RULE7] direction register write-only, reads all ones
// [RULE8] latch and direction apply only in gpio
// [RULE9] select bit three: capture input on pin three
// [RULE10] select bit two: high compare out, pin two
// [RULE11] select bit one: low compare out, pin one
// [RULE12] select bit zero resets, gpio when zero
// [RULE13] select bit zero set drives clock pulse
// [RULE14] timer outputs own driver; capture pin input
package pog_pkg;
    localparam int         PORT_W         = 8;
    localparam logic [7:0] ADDR_DATA      = 8'h00;
    localparam logic [7:0] ADDR_DIR       = 8'h04;
    localparam logic [7:0] ADDR_FSEL      = 8'h08;
    localparam logic [7:0] ADDR_PINS      = 8'h0c;
    localparam logic [7:0] DATA_RST       = 8'h00;
    localparam logic [7:0] DIR_RST        = 8'h00;
    localparam logic [3:0] FSEL_RST       = 4'h0;
    localparam logic [7:0] DIR_READ_VAL   = 8'hff;
    localparam int         SEL_CLKOUT     = 0;
    localparam int         SEL_LOW_CMP    = 1;
    localparam int         SEL_HIGH_CMP   = 2;
    localparam int         SEL_CAPTURE    = 3;

    typedef struct packed {
        logic clock_pulse_output;
        logic timer_f_low_compare_output;
        logic timer_f_high_compare_output;
    } pog_timer_s;
endpackage : pog_pkg

/* hw/pog_port.sv */
// port one gpio with function select, apb slave
`timescale 1ns/1ps
module pog_port (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [7:0]          pin_in,
    output logic      [7:0]          pin_out,
    output logic      [7:0]          pin_oe_n,
    input  pog_pkg::pog_timer_s      timer_in,
    output logic                     capture_input_g
);
    logic [7:0] port_one_data_latch_reg;
    logic [7:0] port_one_direction_control_reg;
    logic [3:0] port_one_function_select_reg;
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] sync3_reg;
    logic [7:0] pin_level_reg;
    logic [7:0] pin_level_next;
    logic [7:0] out_next;
    logic [7:0] oe_n_next;
    logic [31:0] rdata_next;
    logic        setup;
    logic        wr_en;
    logic        addr_ok;

    default clocking cb_bus @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pwrite;
    assign addr_ok = (paddr == pog_pkg::ADDR_DATA) || (paddr == pog_pkg::ADDR_DIR) ||
                     (paddr == pog_pkg::ADDR_FSEL) || (paddr == pog_pkg::ADDR_PINS);

    // slave answers in the access cycle, so pready is one one-cycle pulse per transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !addr_ok;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_one_data_latch_reg <= pog_pkg::DATA_RST; // RULE4
        end else if (wr_en && pready && paddr == pog_pkg::ADDR_DATA) begin
            port_one_data_latch_reg <= pwdata[7:0]; // RULE1
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_one_direction_control_reg <= pog_pkg::DIR_RST; // RULE6
        end else if (wr_en && pready && paddr == pog_pkg::ADDR_DIR) begin
            port_one_direction_control_reg <= pwdata[7:0]; // RULE5
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_one_function_select_reg <= pog_pkg::FSEL_RST; // RULE12
        end else if (wr_en && pready && paddr == pog_pkg::ADDR_FSEL) begin
            port_one_function_select_reg <= pwdata[3:0];
        end
    end

    // pins are asynchronous: three stages, a change counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg     <= 8'h00;
            sync2_reg     <= 8'h00;
            sync3_reg     <= 8'h00;
            pin_level_reg <= 8'h00;
        end else begin
            sync1_reg     <= pin_in;
            sync2_reg     <= sync1_reg;
            sync3_reg     <= sync2_reg;
            pin_level_reg <= pin_level_next;
        end
    end

    generate
        for (genvar i = 0; i < pog_pkg::PORT_W; i++) begin : g_level
            assign pin_level_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : pin_level_reg[i];
        end
    endgenerate

    // pin muxing: latch and direction count only while the pin is in gpio
    always_comb begin
        out_next  = port_one_data_latch_reg; // RULE8
        oe_n_next = ~port_one_direction_control_reg; // RULE5
        if (port_one_function_select_reg[pog_pkg::SEL_CAPTURE]) begin
            out_next[pog_pkg::SEL_CAPTURE]  = 1'b0; // RULE9
            oe_n_next[pog_pkg::SEL_CAPTURE] = 1'b1; // RULE14
        end
        if (port_one_function_select_reg[pog_pkg::SEL_HIGH_CMP]) begin
            out_next[pog_pkg::SEL_HIGH_CMP]  = timer_in.timer_f_high_compare_output; // RULE10
            oe_n_next[pog_pkg::SEL_HIGH_CMP] = 1'b0; // RULE14
        end
        if (port_one_function_select_reg[pog_pkg::SEL_LOW_CMP]) begin
            out_next[pog_pkg::SEL_LOW_CMP]  = timer_in.timer_f_low_compare_output; // RULE11
            oe_n_next[pog_pkg::SEL_LOW_CMP] = 1'b0; // RULE14
        end
        if (port_one_function_select_reg[pog_pkg::SEL_CLKOUT]) begin
            out_next[pog_pkg::SEL_CLKOUT]  = timer_in.clock_pulse_output; // RULE13
            oe_n_next[pog_pkg::SEL_CLKOUT] = 1'b0; // RULE14
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out         <= 8'h00;
            pin_oe_n        <= 8'hff;
            capture_input_g <= 1'b0;
        end else begin
            pin_out         <= out_next;
            pin_oe_n        <= oe_n_next;
            // capture is gated to low in gpio mode so the timer sees no stray edges
            capture_input_g <= port_one_function_select_reg[pog_pkg::SEL_CAPTURE] &&
                               pin_level_reg[pog_pkg::SEL_CAPTURE]; // RULE9
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (paddr)
            pog_pkg::ADDR_DATA: begin
                rdata_next[7:0] = (port_one_direction_control_reg & port_one_data_latch_reg) |
                                  (~port_one_direction_control_reg & pin_level_reg); // RULE2 RULE3
            end
            pog_pkg::ADDR_DIR:  rdata_next[7:0] = pog_pkg::DIR_READ_VAL; // RULE7
            pog_pkg::ADDR_FSEL: rdata_next[3:0] = port_one_function_select_reg;
            pog_pkg::ADDR_PINS: rdata_next[7:0] = pin_level_reg;
            default:            rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= rdata_next;
        end
    end

    a_data_reset: assert property (@(posedge pclk) $rose(presetn) |-> port_one_data_latch_reg == pog_pkg::DATA_RST) // RULE4
        else $error("data latch not zero after reset");
    a_dir_reset: assert property (@(posedge pclk) $rose(presetn) |-> pin_oe_n == 8'hff) // RULE6
        else $error("pins not inputs after reset");
    a_dir_reads_ones: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == pog_pkg::ADDR_DIR |=> prdata[7:0] == pog_pkg::DIR_READ_VAL) // RULE7
        else $error("direction read not all ones");
    a_data_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && pready && paddr == pog_pkg::ADDR_DATA |=> port_one_data_latch_reg == $past(pwdata[7:0])) // RULE1
        else $error("latch write lost");
    a_read_latch: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == pog_pkg::ADDR_DATA |=>
        ((prdata[7:0] ^ $past(port_one_data_latch_reg)) & $past(port_one_direction_control_reg)) == 8'h00) // RULE2
        else $error("output pin read not latch");
    a_read_pin: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == pog_pkg::ADDR_DATA |=>
        ((prdata[7:0] ^ $past(pin_level_reg)) & ~$past(port_one_direction_control_reg)) == 8'h00) // RULE3
        else $error("input pin read not level");
    a_gpio_oe: assert property (@(posedge pclk) disable iff (!presetn)
        port_one_function_select_reg == 4'h0 ##1 port_one_function_select_reg == 4'h0 |->
        pin_oe_n == ~$past(port_one_direction_control_reg) && pin_out == $past(port_one_data_latch_reg)) // RULE8
        else $error("gpio pin drive mismatch");
    a_capture_input: assert property (@(posedge pclk) disable iff (!presetn)
        port_one_function_select_reg[pog_pkg::SEL_CAPTURE] |=> pin_oe_n[pog_pkg::SEL_CAPTURE]) // RULE14
        else $error("capture pin driven");
    a_high_cmp: assert property (@(posedge pclk) disable iff (!presetn)
        port_one_function_select_reg[pog_pkg::SEL_HIGH_CMP] |=> !pin_oe_n[pog_pkg::SEL_HIGH_CMP] &&
        pin_out[pog_pkg::SEL_HIGH_CMP] == $past(timer_in.timer_f_high_compare_output)) // RULE10
        else $error("high compare not routed");
    a_low_cmp: assert property (@(posedge pclk) disable iff (!presetn)
        port_one_function_select_reg[pog_pkg::SEL_LOW_CMP] |=> !pin_oe_n[pog_pkg::SEL_LOW_CMP] &&
        pin_out[pog_pkg::SEL_LOW_CMP] == $past(timer_in.timer_f_low_compare_output)) // RULE11
        else $error("low compare not routed");
    a_clk_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        port_one_function_select_reg[pog_pkg::SEL_CLKOUT] |=> !pin_oe_n[pog_pkg::SEL_CLKOUT] &&
        pin_out[pog_pkg::SEL_CLKOUT] == $past(timer_in.clock_pulse_output)) // RULE13
        else $error("clock pulse not routed");

    // named steps of one apb transfer, shared by the bus checks below
    sequence s_any_setup;
        psel && !penable;
    endsequence

    sequence s_read_setup(logic [7:0] a);
        setup && !pwrite && paddr == a;
    endsequence

    sequence s_write_access(logic [7:0] a);
        wr_en && pready && paddr == a;
    endsequence

    // one answer per setup: a held ready would complete a second transfer
    a_pready_answer: assert property (
        s_any_setup |=>
        pready)
        else $error("no ready after setup");

    a_pready_pulse: assert property (
        pready |=>
        !pready)
        else $error("ready held past one cycle");

    a_slverr_unmapped: assert property (
        setup && !addr_ok |=>
        pslverr)
        else $error("unmapped access not flagged");

    a_slverr_mapped: assert property (
        setup && addr_ok |=>
        !pslverr)
        else $error("mapped access flagged");

    a_slverr_with_ready: assert property (
        pslverr |->
        pready)
        else $error("error without ready");
    // unmapped reads give zero so software never sees stale data
    a_unmapped_read: assert property (
        setup && !pwrite && !addr_ok |=>
        prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    // read data stands until the next read setup
    a_rdata_hold: assert property (
        !(setup && !pwrite) |=>
        $stable(prdata))
        else $error("read data moved");

    a_upper_zero: assert property (
        setup && !pwrite |=>
        prdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");

    a_read_fsel: assert property ( // RULE9
        s_read_setup(pog_pkg::ADDR_FSEL) |=>
        prdata[3:0] == $past(port_one_function_select_reg))
        else $error("select read mismatch");

    a_read_pins: assert property ( // RULE3
        s_read_setup(pog_pkg::ADDR_PINS) |=>
        prdata[7:0] == $past(pin_level_reg))
        else $error("pin level read mismatch");
    // register writes land only at the access edge
    a_dir_write: assert property ( // RULE5
        s_write_access(pog_pkg::ADDR_DIR) |=>
        port_one_direction_control_reg == $past(pwdata[7:0]))
        else $error("direction write lost");

    a_fsel_write: assert property ( // RULE9
        s_write_access(pog_pkg::ADDR_FSEL) |=>
        port_one_function_select_reg == $past(pwdata[3:0]))
        else $error("select write lost");

    a_latch_hold: assert property ( // RULE1
        !(wr_en && pready && paddr == pog_pkg::ADDR_DATA) |=>
        $stable(port_one_data_latch_reg))
        else $error("latch changed without write");

    a_dir_hold: assert property ( // RULE5
        !(wr_en && pready && paddr == pog_pkg::ADDR_DIR) |=>
        $stable(port_one_direction_control_reg))
        else $error("direction changed without write");

    a_fsel_hold: assert property ( // RULE12
        !(wr_en && pready && paddr == pog_pkg::ADDR_FSEL) |=>
        $stable(port_one_function_select_reg))
        else $error("select changed without write");

    a_latch_read_keeps: assert property ( // RULE1
        s_read_setup(pog_pkg::ADDR_DATA) |=>
        $stable(port_one_data_latch_reg))
        else $error("read altered latch");

    a_dir_read_keeps: assert property ( // RULE7
        s_read_setup(pog_pkg::ADDR_DIR) |=>
        $stable(port_one_direction_control_reg))
        else $error("read altered direction");

    a_fsel_reset: assert property ( // RULE12
        $rose(presetn) |->
        port_one_function_select_reg == pog_pkg::FSEL_RST)
        else $error("select not clear after reset");

    a_out_reset: assert property ( // RULE4
        $rose(presetn) |->
        pin_out == pog_pkg::DATA_RST && !capture_input_g)
        else $error("pin drive not clear after reset");
    // the timer sees the filtered pin only while the pin is handed to it
    a_capture_gated: assert property ( // RULE9
        !port_one_function_select_reg[pog_pkg::SEL_CAPTURE] |=>
        !capture_input_g)
        else $error("capture active in gpio mode");

    a_capture_follow: assert property ( // RULE9
        port_one_function_select_reg[pog_pkg::SEL_CAPTURE] |=>
        capture_input_g == $past(pin_level_reg[pog_pkg::SEL_CAPTURE]))
        else $error("capture not following pin");

    a_capture_out_low: assert property ( // RULE14
        port_one_function_select_reg[pog_pkg::SEL_CAPTURE] |=>
        !pin_out[pog_pkg::SEL_CAPTURE])
        else $error("capture pin drive value not low");
    // a level moves only when stages two and three agree, so a glitch of one sample never reaches software
    a_level_settle: assert property (
        sync2_reg == sync3_reg |=>
        pin_level_reg == $past(sync3_reg))
        else $error("settled pin level not taken");

    a_level_hold: assert property (
        sync2_reg != sync3_reg |=>
        ((pin_level_reg ^ $past(pin_level_reg)) & $past(sync2_reg ^ sync3_reg)) == 8'h00)
        else $error("unsettled pin level taken");
    // pins 7 to 4 have no timer role and always follow the gpio registers
    a_upper_gpio: assert property ( // RULE8
        1'b1 |=>
        pin_oe_n[7:4] == ~$past(port_one_direction_control_reg[7:4]) && pin_out[7:4] == $past(port_one_data_latch_reg[7:4]))
        else $error("upper pin drive mismatch");

    // low pins follow the gpio registers whenever their own select bit is clear
    generate
        for (genvar i = 0; i < $bits(port_one_function_select_reg); i++) begin : g_gpio_chk
            a_low_gpio: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
                !port_one_function_select_reg[i] |=>
                pin_oe_n[i] == ~$past(port_one_direction_control_reg[i]) && pin_out[i] == $past(port_one_data_latch_reg[i]))
                else $error("low pin drive mismatch");
        end
    endgenerate
endmodule : pog_port

/* verif/pog_board.sv */
// board model on the port pins: loops back driven pins, drives the rest
`timescale 1ns/1ps
module pog_board (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_in
);
    // a driven pin reads back its own level; the board never fights the port driver
    assign pin_in = (pin_out & ~pin_oe_n) | (ext_val & pin_oe_n);
endmodule : pog_board

/* verif/port_one_gpio_with_function_select_bench.sv */
// self-checking bench for the port one gpio block
`timescale 1ns/1ps
module port_one_gpio_with_function_select_bench;
    logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, capture_input_g, rerr;
    logic [7:0]          paddr, ext_val, pin_in, pin_out, pin_oe_n, lat, dir, e;
    logic [31:0]         pwdata, prdata, rd;
    logic [2:0]          t;
    pog_pkg::pog_timer_s timer_in;
    int                  n_fail, cmp_count, cyc;
    integer              seed;

    pog_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .timer_in(timer_in), .capture_input_g(capture_input_g));
    pog_board u_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val), .pin_in(pin_in));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic summarize;
        $display("checks %0d failures %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // an idle edge first, so a release and the next setup never share a time step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20)
            n_fail++;
        rd      = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            summarize();
        end
    end

    initial begin
        seed = 32'hc0513bc9;
        {n_fail, cmp_count, cyc} = '0;
        {presetn, psel, penable, pwrite, paddr, pwdata, timer_in} = '0;
        ext_val = 8'h5a;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        #1 chk(pin_oe_n, 8'hff);
        apb(1'b0, pog_pkg::ADDR_DIR, 32'h0);
        chk(rd, {24'h0, pog_pkg::DIR_READ_VAL});
        apb(1'b0, pog_pkg::ADDR_FSEL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, pog_pkg::ADDR_DIR, 32'hff);
        apb(1'b0, pog_pkg::ADDR_DATA, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, pog_pkg::ADDR_DIR, 32'h0);
        chk(rd, {24'h0, pog_pkg::DIR_READ_VAL});
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        $display("test reset and map done");
        for (int i = 0; i < 12; i++) begin
            lat = 8'($random(seed));
            dir = 8'($random(seed));
            e   = 8'($random(seed));
            apb(1'b1, pog_pkg::ADDR_DATA, {24'h0, lat});
            apb(1'b1, pog_pkg::ADDR_DIR, {24'h0, dir});
            ext_val <= e;
            repeat (6) @(posedge pclk);
            #1 chk(pin_oe_n, 8'(~dir));
            chk(pin_out & dir, lat & dir);
            apb(1'b0, pog_pkg::ADDR_DATA, 32'h0);
            chk(rd, {24'h0, (lat & dir) | (e & ~dir)});
            apb(1'b0, pog_pkg::ADDR_PINS, 32'h0);
            chk(rd, {24'h0, (lat & dir) | (e & ~dir)});
            chk({31'h0, rerr}, 32'h0);
        end
        $display("test direction and data done");
        apb(1'b1, pog_pkg::ADDR_FSEL, 32'hf);
        for (int i = 0; i < 8; i++) begin
            t = 3'($random(seed));
            e = 8'($random(seed));
            apb(1'b1, pog_pkg::ADDR_DIR, i[0] ? 32'hff : 32'h0);
            timer_in <= t;
            ext_val  <= e;
            repeat (6) @(posedge pclk);
            #1 chk(pin_oe_n, i[0] ? 8'h08 : 8'hf8);
            chk(pin_out[2:0], {t[0], t[1], t[2]});
            chk(capture_input_g, e[3]);
        end
        apb(1'b1, pog_pkg::ADDR_DIR, 32'h0);
        apb(1'b1, pog_pkg::ADDR_FSEL, 32'h0);
        ext_val <= 8'hff;
        repeat (6) @(posedge pclk);
        #1 chk(pin_oe_n, 8'hff);
        chk(capture_input_g, 1'b0);
        $display("test function select done");
        summarize();
    end
endmodule : port_one_gpio_with_function_select_bench
